// file: bench/async_uart_rx_multiproc_tb_top.sv
// self-checking bench for the serial unit against a far-side model
`timescale 1ns/1ps
module async_uart_rx_multiproc_tb_top;
    import uart_pkg::*;
    logic mclk, rst, clk_en, baud_tick, rxd, txd;
    frame_fmt_t fmt;
    logic rx_enable_bit, tx_enable_bit, rx_int_enable, tx_empty_int_enable;
    logic tx_end_int_enable, mp_filter_set, rx_full_clear, overrun_clear;
    logic framing_clear, parity_clear, dma_rx_read, tx_write, mp_bit_to_send;
    logic [7:0] tx_data;
    rx_word_t rx_holding_reg;
    logic rx_word_valid, rx_word_ready, rx_full_flag, overrun_flag;
    logic framing_error_flag, parity_error_flag, mp_filter_enable;
    logic tx_empty_flag, tx_end_flag, rx_full_irq, rx_error_irq;
    logic tx_empty_irq, tx_end_irq;
    int n_errors = 0;
    int cmp_count = 0;
    int k;

    serial_unit dut_u (.mclk, .rst, .clk_en, .baud_tick, .fmt, .rx_enable_bit,
        .tx_enable_bit, .rx_int_enable, .tx_empty_int_enable, .tx_end_int_enable,
        .mp_filter_set, .rx_full_clear, .overrun_clear, .framing_clear,
        .parity_clear, .dma_rx_read, .tx_write, .tx_data, .mp_bit_to_send, .rxd,
        .txd, .rx_holding_reg, .rx_word_valid, .rx_word_ready, .rx_full_flag,
        .overrun_flag, .framing_error_flag, .parity_error_flag, .mp_filter_enable,
        .tx_empty_flag, .tx_end_flag, .rx_full_irq, .rx_error_irq, .tx_empty_irq,
        .tx_end_irq);

    uart_partner #(.BIT(32)) partner_u (.mclk(mclk), .rxd(rxd), .txd(txd));

    // ---------------------------------------------------------------
    // clock and oversample tick (one tick every two cycles)
    // ---------------------------------------------------------------
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) #1 baud_tick = ~baud_tick;

    task automatic results;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic chk_word(input logic [8:0] got, input logic [8:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h", $time, m, got);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge mclk);
        #1;
        s = 1'b0;
    endtask

    // frame on rxd in the current format, then let the flags settle
    task automatic rxf(input logic [7:0] d, input logic x, input logic st);
        partner_u.send(d, fmt.seven_bit ? 7 : 8, fmt.parity_en | fmt.mp_format,
                       x, st, fmt.two_stop);
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {rst, clk_en, baud_tick, fmt} = {3'h6, 5'h00};
        {rx_enable_bit, tx_enable_bit, rx_int_enable} = 3'h7;
        {tx_empty_int_enable, tx_end_int_enable, mp_filter_set} = 3'h6;
        {rx_full_clear, overrun_clear, framing_clear, parity_clear} = 4'h0;
        {dma_rx_read, tx_write, mp_bit_to_send, rx_word_ready} = 4'h1;
        tx_data = 8'h00;
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;
        chk_bit(txd, 1'b1, "txd idle");
        chk_bit(tx_empty_flag & tx_end_flag, 1'b1, "tx flags reset");
        chk_bit(rx_full_flag, 1'b0, "rx full reset");
        // good frame, then one more while still full
        rxf(8'hA5, 1'b0, 1'b1);
        chk_bit(rx_full_flag, 1'b1, "full after frame");
        chk_word(rx_holding_reg, {8'hA5, 1'b0}, "rx data");
        chk_bit(rx_full_irq, 1'b1, "full irq");
        rxf(8'h3C, 1'b0, 1'b1);
        chk_bit(overrun_flag, 1'b1, "overrun");
        chk_word(rx_holding_reg, {8'hA5, 1'b0}, "kept data");
        chk_bit(rx_error_irq, 1'b1, "error irq");
        pulse(rx_full_clear);
        rxf(8'h11, 1'b0, 1'b1);
        chk_bit(rx_full_flag, 1'b0, "blocked by error");
        pulse(overrun_clear);
        // even parity wrong, then odd parity right
        fmt = 5'h08;
        rxf(8'h5A, ~(^8'h5A), 1'b1);
        chk_bit(parity_error_flag, 1'b1, "parity error");
        chk_word(rx_holding_reg, {8'h5A, 1'b0}, "parity data");
        pulse(parity_clear);
        fmt = 5'h0C;
        rxf(8'h5A, ~(^8'h5A), 1'b1);
        chk_bit(rx_full_flag & ~parity_error_flag, 1'b1, "odd parity ok");
        pulse(dma_rx_read);
        chk_bit(rx_full_flag, 1'b0, "dma clears full");
        // low stop, then a two-stop frame
        fmt = 5'h00;
        rxf(8'h81, 1'b0, 1'b0);
        chk_bit(framing_error_flag, 1'b1, "framing error");
        chk_word(rx_holding_reg, {8'h81, 1'b0}, "framing data");
        pulse(framing_clear);
        fmt = 5'h01;
        rxf(8'h42, 1'b0, 1'b1);
        chk_bit(rx_full_flag & ~framing_error_flag, 1'b1, "two stop");
        pulse(rx_full_clear);
        // buffer: three words with the reader stalled, two kept
        rx_word_ready = 1'b0;
        for (int i = 1; i < 4; i++) begin
            rxf(8'(i), 1'b0, 1'b1);
            pulse(rx_full_clear);
        end
        k = 0;
        rx_word_ready = 1'b1;
        repeat (4) begin
            k += int'(rx_word_valid === 1'b1);
            @(posedge mclk);
            #1;
        end
        chk_word(9'(k), 9'h002, "buffer words");
        // multiprocessor receive, parity enable ignored
        fmt = 5'h0A;
        pulse(mp_filter_set);
        rxf(8'h07, 1'b0, 1'b1);
        chk_bit(rx_full_flag | parity_error_flag, 1'b0, "skipped");
        rxf(8'h07, 1'b1, 1'b1);
        chk_word(rx_holding_reg, {8'h07, 1'b1}, "id frame");
        chk_bit(mp_filter_enable, 1'b0, "filter off");
        pulse(rx_full_clear);
        rxf(8'h31, 1'b0, 1'b1);
        chk_bit(rx_full_flag & ~parity_error_flag, 1'b1, "no parity");
        pulse(rx_full_clear);
        // multiprocessor transmit, two frames back to back
        fmt = 5'h02;
        {tx_data, mp_bit_to_send} = {8'hC3, 1'b1};
        pulse(tx_write);
        k = 0;
        while (tx_empty_flag !== 1'b1 && k < 100) begin
            @(posedge mclk);
            #1;
            k++;
        end
        @(posedge mclk);
        #1;
        chk_bit(tx_empty_irq & ~tx_end_flag, 1'b1, "loaded");
        {tx_data, mp_bit_to_send} = {8'h5E, 1'b0};
        pulse(tx_write);
        k = 0;
        while (tx_end_flag !== 1'b1 && k < 1000) begin
            @(posedge mclk);
            #1;
            k++;
        end
        @(posedge mclk);
        #1;
        chk_bit(tx_end_irq & txd, 1'b1, "end irq and marking");
        chk_word(9'(partner_u.got_q.size()), 9'h002, "frame count");
        chk_word(partner_u.got_q[0], {8'hC3, 1'b1}, "tx id");
        chk_word(partner_u.got_q[1], {8'h5E, 1'b0}, "tx data");
        // disable transmit in mid-frame
        pulse(tx_write);
        repeat (100) @(posedge mclk);
        #1;
        tx_enable_bit = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk_bit(tx_empty_flag & txd, 1'b1, "tx disable");
        results();
    end
endmodule

// file: bench/uart_partner.sv
// far-side serial transceiver model: drives rxd, decodes txd frames
`timescale 1ns/1ps
module uart_partner #(
    parameter int BIT = 32
) (
    // clock
    input wire logic mclk,
    // serial line
    output logic rxd,
    input wire logic txd
);
    logic [8:0] got_q[$];
    logic [8:0] cap;

    // one bit time on rxd; line idles high, driven by the model
    task automatic put(input logic v);
        rxd = v;
        repeat (BIT) @(posedge mclk);
        #1;
    endtask

    // whole frame: start, data lsb first, optional extra bit, stop bits
    task automatic send(input logic [7:0] d, input int nb, input logic hx,
                        input logic x, input logic st, input logic two);
        put(1'b0);
        for (int i = 0; i < nb; i++)
            put(d[i]);
        if (hx)
            put(x);
        put(st);
        if (two)
            put(1'b1);
        rxd = 1'b1;
    endtask

    initial rxd = 1'b1;

    // decode 8 data bits plus the multiprocessor bit, sampled mid-bit
    initial forever begin
        @(negedge mclk);
        if (txd === 1'b0) begin
            repeat (BIT / 2) @(negedge mclk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(negedge mclk);
                cap = {txd, cap[8:1]};
            end
            got_q.push_back({cap[7:0], cap[8]});
            repeat (BIT) @(negedge mclk);
        end
    end
endmodule

// file: rtl/serial_unit.sv
// asynchronous serial receiver and multiprocessor transmitter
`timescale 1ns/1ps
module serial_unit
    import uart_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic baud_tick,
    // mode and control
    input wire frame_fmt_t fmt,
    input wire logic rx_enable_bit,
    input wire logic tx_enable_bit,
    input wire logic rx_int_enable,
    input wire logic tx_empty_int_enable,
    input wire logic tx_end_int_enable,
    input wire logic mp_filter_set,
    // status clears from software
    input wire logic rx_full_clear,
    input wire logic overrun_clear,
    input wire logic framing_clear,
    input wire logic parity_clear,
    input wire logic dma_rx_read,
    // transmit holding register load
    input wire logic tx_write,
    input wire logic [7:0] tx_data,
    input wire logic mp_bit_to_send,
    // serial pins
    input wire logic rxd,
    output logic txd,
    // receive data stream
    output rx_word_t rx_holding_reg,
    output logic rx_word_valid,
    input wire logic rx_word_ready,
    // status
    output logic rx_full_flag,
    output logic overrun_flag,
    output logic framing_error_flag,
    output logic parity_error_flag,
    output logic mp_filter_enable,
    output logic tx_empty_flag,
    output logic tx_end_flag,
    // interrupt requests
    output logic rx_full_irq,
    output logic rx_error_irq,
    output logic tx_empty_irq,
    output logic tx_end_irq
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [3:0] data_len(input frame_fmt_t f);
        data_len = f.seven_bit ? DATA_BITS_7 : DATA_BITS_8;
    endfunction

    function automatic logic has_extra(input frame_fmt_t f);
        has_extra = f.mp_format | f.parity_en;
    endfunction

    // -----------------------------------------------------------------
    // receiver
    // -----------------------------------------------------------------
    line_state_t rx_state;
    logic [3:0] rx_tick;
    logic [3:0] rx_bitn;
    logic [7:0] rx_shift_reg;
    logic rx_extra;
    logic rx_par;
    logic rx_fire;

    wire logic err_any = overrun_flag | framing_error_flag | parity_error_flag;
    wire logic rx_mid = baud_tick & (rx_tick == HALF_BIT);
    wire logic rx_bit_end = baud_tick & (rx_tick == LAST_TICK);
    wire logic [3:0] rx_len = data_len(fmt);
    wire logic parity_bad = fmt.parity_en & ~fmt.mp_format &
                            ((rx_par ^ rx_extra) != fmt.parity_odd);
    wire logic stop_bad = (rxd != LINE_IDLE);
    wire logic frame_done = (rx_state == ST_STOP) & rx_bit_end;
    wire logic skip_frame = mp_filter_enable & ~rx_extra;
    wire logic take_frame = frame_done & ~skip_frame;
    wire logic store_ok = take_frame & ~rx_full_flag;
    wire logic clr_full = rx_full_clear | dma_rx_read;
    wire logic [7:0] rx_aligned = fmt.seven_bit ? (rx_shift_reg >> 1) & MSB_MASK_7
                                                : rx_shift_reg;

    // bit timing and shifting
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_state <= ST_IDLE;
            rx_tick <= BIT_ZERO;
            rx_bitn <= BIT_ZERO;
            rx_shift_reg <= BYTE_ZERO;
            rx_extra <= 1'b0;
            rx_par <= 1'b0;
        end else if (clk_en) begin
            if (baud_tick)
                rx_tick <= rx_tick + BIT_ONE;
            case (rx_state)
                ST_IDLE: begin
                    // error flags hold the receiver off
                    if (rx_enable_bit && !err_any && rxd == LINE_START) begin
                        rx_state <= ST_START;
                        rx_tick <= BIT_ZERO;
                    end
                end
                ST_START: begin
                    if (rx_mid) begin
                        if (rxd != LINE_START)
                            rx_state <= ST_IDLE;
                        else begin
                            rx_state <= ST_DATA;
                            rx_tick <= BIT_ZERO;
                            rx_bitn <= BIT_ZERO;
                            rx_par <= 1'b0;
                        end
                    end
                end
                ST_DATA: begin
                    if (baud_tick && rx_tick == LAST_TICK) begin
                        rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
                        rx_par <= rx_par ^ rxd;
                        rx_bitn <= rx_bitn + BIT_ONE;
                        if (rx_bitn + BIT_ONE == rx_len)
                            rx_state <= has_extra(fmt) ? ST_EXTRA : ST_STOP;
                    end
                end
                ST_EXTRA: begin
                    if (rx_bit_end) begin
                        rx_extra <= rxd;
                        rx_state <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // first stop bit sampled at its centre; second is idle line
                    if (rx_bit_end)
                        rx_state <= ST_IDLE;
                end
                default: rx_state <= ST_IDLE;
            endcase
            if (rx_state == ST_DATA && rx_bitn == BIT_ZERO && rx_tick == BIT_ZERO)
                rx_extra <= 1'b0;
        end
    end

    // status flags, set wins over clear except mp_filter_enable, where the id-frame clear wins over mp_filter_set
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            mp_filter_enable <= 1'b0;
            rx_holding_reg <= '0;
            rx_fire <= 1'b0;
            rx_full_irq <= 1'b0;
            rx_error_irq <= 1'b0;
        end else if (clk_en) begin
            rx_fire <= store_ok;
            if (store_ok) begin
                // parity bit is not an mp bit: keep it out of the word
                rx_holding_reg <= '{data: rx_aligned, mp_bit: rx_extra & fmt.mp_format};
                rx_full_flag <= ~(stop_bad | parity_bad);
            end else if (clr_full)
                rx_full_flag <= 1'b0;
            if (take_frame && rx_full_flag)
                overrun_flag <= 1'b1;
            else if (overrun_clear)
                overrun_flag <= 1'b0;
            if (store_ok && stop_bad)
                framing_error_flag <= 1'b1;
            else if (framing_clear)
                framing_error_flag <= 1'b0;
            if (store_ok && parity_bad)
                parity_error_flag <= 1'b1;
            else if (parity_clear)
                parity_error_flag <= 1'b0;
            if (frame_done && fmt.mp_format && rx_extra)
                mp_filter_enable <= 1'b0;
            else if (mp_filter_set)
                mp_filter_enable <= 1'b1;
            rx_full_irq <= rx_int_enable & rx_full_flag;
            rx_error_irq <= rx_int_enable & err_any;
        end
    end

    // -----------------------------------------------------------------
    // two-entry buffer toward the consumer
    // -----------------------------------------------------------------
    rx_word_t buf_mem [2];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    wire logic buf_ready = (buf_cnt != BUF_DEPTH);
    wire logic buf_push = rx_fire & buf_ready;
    wire logic buf_pop = rx_word_valid & rx_word_ready;
    wire logic [1:0] next_buf_cnt = buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};

    // words overflow silently only if the consumer stalls past two frames
    always_ff @(posedge mclk) begin
        if (rst) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            rx_word_valid <= 1'b0;
        end else if (clk_en) begin
            if (buf_push) begin
                buf_mem[buf_wp] <= rx_holding_reg;
                buf_wp <= ~buf_wp;
            end
            if (buf_pop)
                buf_rp <= ~buf_rp;
            buf_cnt <= next_buf_cnt;
            rx_word_valid <= (next_buf_cnt != 2'h0); // valid straight from a flop
        end
    end

    // -----------------------------------------------------------------
    // transmitter
    // -----------------------------------------------------------------
    line_state_t tx_state;
    logic [3:0] tx_tick;
    logic [3:0] tx_bitn;
    logic [7:0] tx_holding_reg;
    logic tx_mp_hold;
    logic [7:0] tx_shift_reg;
    logic tx_mp;
    logic tx_par;

    wire logic tx_bit_end = baud_tick & (tx_tick == LAST_TICK);
    wire logic tx_load_idle = (tx_state == ST_IDLE) & ~tx_empty_flag & tx_enable_bit;
    wire logic tx_last_stop = tx_bit_end &
                 (((tx_state == ST_STOP) & ~fmt.two_stop) | (tx_state == ST_STOP2));
    wire logic tx_chain = tx_last_stop & ~tx_empty_flag;
    wire logic tx_load = tx_load_idle | tx_chain;
    wire logic tx_extra_val = fmt.mp_format ? tx_mp
                                            : (tx_par ^ fmt.parity_odd);

    // holding register and empty flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_holding_reg <= BYTE_ZERO;
            tx_mp_hold <= 1'b0;
            tx_empty_flag <= 1'b1;
        end else if (clk_en) begin
            if (!tx_enable_bit)
                tx_empty_flag <= 1'b1;
            else if (tx_write) begin
                tx_holding_reg <= tx_data;
                tx_mp_hold <= mp_bit_to_send;
                tx_empty_flag <= 1'b0;
            end else if (tx_load)
                tx_empty_flag <= 1'b1;
        end
    end

    // frame sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_state <= ST_IDLE;
            tx_tick <= BIT_ZERO;
            tx_bitn <= BIT_ZERO;
            tx_shift_reg <= BYTE_ZERO;
            tx_mp <= 1'b0;
            tx_par <= 1'b0;
            txd <= LINE_IDLE;
            tx_end_flag <= 1'b1;
            tx_empty_irq <= 1'b0;
            tx_end_irq <= 1'b0;
        end else if (clk_en) begin
            tx_empty_irq <= tx_empty_int_enable & tx_empty_flag;
            tx_end_irq <= tx_end_int_enable & tx_end_flag;
            if (baud_tick)
                tx_tick <= tx_tick + BIT_ONE;
            if (!tx_enable_bit) begin
                tx_state <= ST_IDLE;
                tx_shift_reg <= BYTE_ZERO;
                txd <= LINE_IDLE;
                tx_end_flag <= 1'b1;
            end else if (tx_load) begin
                tx_shift_reg <= tx_holding_reg;
                tx_mp <= tx_mp_hold;
                tx_par <= ^tx_holding_reg;
                tx_state <= ST_START;
                tx_tick <= BIT_ZERO;
                tx_end_flag <= 1'b0;
                txd <= LINE_START;
            end else begin
                case (tx_state)
                    ST_IDLE: txd <= LINE_IDLE;
                    ST_START: begin
                        if (tx_bit_end) begin
                            tx_state <= ST_DATA;
                            tx_bitn <= BIT_ZERO;
                            txd <= tx_shift_reg[0];
                            tx_shift_reg <= tx_shift_reg >> 1;
                        end
                    end
                    ST_DATA: begin
                        if (tx_bit_end) begin
                            tx_bitn <= tx_bitn + BIT_ONE;
                            if (tx_bitn + BIT_ONE == data_len(fmt)) begin
                                tx_state <= has_extra(fmt) ? ST_EXTRA : ST_STOP;
                                txd <= has_extra(fmt) ? tx_extra_val : LINE_IDLE;
                            end else begin
                                txd <= tx_shift_reg[0];
                                tx_shift_reg <= tx_shift_reg >> 1;
                            end
                        end
                    end
                    ST_EXTRA: begin
                        if (tx_bit_end) begin
                            tx_state <= ST_STOP;
                            txd <= LINE_IDLE;
                        end
                    end
                    ST_STOP: begin
                        if (tx_bit_end) begin
                            tx_state <= fmt.two_stop ? ST_STOP2 : ST_IDLE;
                            if (!fmt.two_stop)
                                tx_end_flag <= 1'b1;
                        end
                    end
                    ST_STOP2: begin
                        if (tx_bit_end) begin
                            tx_state <= ST_IDLE;
                            tx_end_flag <= 1'b1;
                        end
                    end
                    default: tx_state <= ST_IDLE;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_store;
        store_ok & ~stop_bad & ~parity_bad & clk_en;
    endsequence
    property p_full_on_store;
        @(posedge mclk) disable iff (rst) s_store |=> rx_full_flag;
    endproperty
    a_full_on_store: assert property (p_full_on_store) else $error("full not set");
    property p_overrun;
        @(posedge mclk) disable iff (rst)
            (take_frame & rx_full_flag & clk_en) |=> overrun_flag && $stable(rx_holding_reg);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun lost");
    property p_err_stop;
        @(posedge mclk) disable iff (rst) err_any |-> ##1 (rx_state != ST_START || $past(rx_state) != ST_IDLE);
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("rx after error");
    property p_dma_clear;
        @(posedge mclk) disable iff (rst) (dma_rx_read & ~store_ok & clk_en) |=> !rx_full_flag;
    endproperty
    a_dma_clear: assert property (p_dma_clear) else $error("dma no clear");
    property p_tx_disable;
        @(posedge mclk) disable iff (rst) (!tx_enable_bit & clk_en) |=> tx_empty_flag && txd;
    endproperty
    a_tx_disable: assert property (p_tx_disable) else $error("tx disable");
    property p_tx_load;
        @(posedge mclk) disable iff (rst) (tx_load & tx_enable_bit & ~tx_write & clk_en)
            |=> tx_empty_flag && !txd && tx_state == ST_START;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("tx load");
    property p_mp_latch;
        @(posedge mclk) disable iff (rst) (tx_load & tx_enable_bit & clk_en) |=> tx_mp == $past(tx_mp_hold);
    endproperty
    a_mp_latch: assert property (p_mp_latch) else $error("mp bit");
    property p_skip;
        @(posedge mclk) disable iff (rst) (frame_done & skip_frame & clk_en) |=> $stable(rx_full_flag) || !rx_full_flag;
    endproperty
    a_skip: assert property (p_skip) else $error("skip set full");
    property p_irq;
        @(posedge mclk) disable iff (rst) (rx_int_enable & rx_full_flag & clk_en) |=> rx_full_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no rx irq");
endmodule

// file: rtl/uart_pkg.sv
// constants and carrier types shared by the serial unit
package uart_pkg;
    // -----------------------------------------------------------------
    // oversampling and frame layout
    // -----------------------------------------------------------------
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] HALF_BIT = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hF;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_7 = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] MSB_MASK_7 = 8'h7F;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_START = 1'b0;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // -----------------------------------------------------------------
    // carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic seven_bit;
        logic parity_en;
        logic parity_odd;
        logic mp_format;
        logic two_stop;
    } frame_fmt_t;

    typedef struct packed {
        logic [7:0] data;
        logic mp_bit;
    } rx_word_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_EXTRA,
        ST_STOP,
        ST_STOP2
    } line_state_t;
endpackage
